/* File: core/rcc_regs.sv */
// Configuration registers for converter channel 1 and channel 2 target voltage.
// Assumes the serial port logic, factory settings and power sequencer share clk.
// Functional notes
// [RULE1] Channel 1 style field picks auto, buck, boost or buck-boost.
// [RULE2] Channel 1 limit field picks 1.000, 0.750, 0.500 or 0.333 A.
// [RULE3] Discharge bit set and channel off turns the pull-down on.
// [RULE4] Enable codes 0 to 3 follow power sequencer slot 0 to 3.
// [RULE5] Codes 4,5 force channel off; codes 6,7 force it on.
// [RULE6] Software puts bias to normal power before enabling the channel.
// [RULE7] Channel 2 setpoint is 0.5 V plus 25 mV per code.
// [RULE8] Codes 0xC8 and above saturate at 5.500 V.
// [RULE9] Reset loads every field from factory settings; all stay read/write.
`default_nettype none
module rcc_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire rcc_pkg::rcc_req_s req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic [7:0] factory_ch1,
    input wire logic [7:0] factory_ch2,
    input wire logic [rcc_pkg::SLOTS-1:0] slot_on,
    output logic ch1_on,
    output logic ch1_discharge_on,
    output rcc_pkg::rcc_style_e ch1_style,
    output logic [9:0] ch1_peak_limit_ma,
    output logic [15:0] ch2_setpoint_mv
);
    typedef struct packed {
        logic loaded;
        rcc_pkg::rcc_ch1_s ch1;
        logic [7:0] ch2;
        logic [7:0] rd_data;
        logic rd_valid;
        logic on;
        logic disch;
        logic [9:0] ilim_ma;
        logic [15:0] mv;
    } rcc_state_s;

    logic [1:0] rst_sync_q;
    logic rst_n;
    rcc_state_s s_q, s_d;
    logic [15:0] mv_dec;
    logic en_next;

    // Reset enters asynchronously, leaves synchronously
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    rcc_vdecode u_vdecode (
        .code(s_q.ch2),
        .setpoint_mv(mv_dec)
    );

    always_comb begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        if (!s_q.loaded) begin
            // Straps sampled one clock after release, never under reset
            s_d.ch1 = rcc_pkg::rcc_ch1_s'(factory_ch1); // see [RULE9]
            s_d.ch2 = factory_ch2; // see [RULE9]
            s_d.loaded = 1'b1;
        end else if (req.wr) begin
            if (req.addr == rcc_pkg::CH1_OFS) begin
                s_d.ch1 = rcc_pkg::rcc_ch1_s'(req.wdata); // see [RULE9]
            end else if (req.addr == rcc_pkg::CH2_OFS) begin
                s_d.ch2 = req.wdata; // see [RULE9]
            end
        end
        if (req.rd) begin
            s_d.rd_valid = 1'b1;
            if (req.addr == rcc_pkg::CH1_OFS) begin
                s_d.rd_data = s_q.ch1;
            end else if (req.addr == rcc_pkg::CH2_OFS) begin
                s_d.rd_data = s_q.ch2;
            end else begin
                s_d.rd_data = 8'h00;
            end
        end
        // Forced codes override the sequencer, slot codes follow it
        if (s_q.ch1.enable_control_ch1[rcc_pkg::EN_FORCE_BIT]) begin
            en_next = s_q.ch1.enable_control_ch1[rcc_pkg::EN_ON_BIT]; // see [RULE5]
        end else begin
            en_next = slot_on[s_q.ch1.enable_control_ch1[1:0]]; // see [RULE4]
        end
        s_d.on = en_next & s_q.loaded;
        s_d.disch = s_q.ch1.discharge_enable_ch1 & ~s_d.on; // see [RULE3]
        unique case (s_q.ch1.peak_current_limit_ch1) // see [RULE2]
            2'b00: s_d.ilim_ma = rcc_pkg::ILIM_00_MA;
            2'b01: s_d.ilim_ma = rcc_pkg::ILIM_01_MA;
            2'b10: s_d.ilim_ma = rcc_pkg::ILIM_10_MA;
            2'b11: s_d.ilim_ma = rcc_pkg::ILIM_11_MA;
        endcase
        s_d.mv = mv_dec; // see [RULE7]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign rd_valid = s_q.rd_valid;
    assign ch1_on = s_q.on;
    assign ch1_discharge_on = s_q.disch;
    assign ch1_style = s_q.ch1.conversion_style; // see [RULE1]
    assign ch1_peak_limit_ma = s_q.ilim_ma;
    assign ch2_setpoint_mv = s_q.mv;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence wr_ch1_s;
        s_q.loaded && req.wr && req.addr == rcc_pkg::CH1_OFS;
    endsequence

    sequence wr_ch2_s;
        s_q.loaded && req.wr && req.addr == rcc_pkg::CH2_OFS;
    endsequence

    // Read decodes, one per register and one for the holes in the map
    sequence rd_ch1_s;
        s_q.loaded && req.rd && req.addr == rcc_pkg::CH1_OFS;
    endsequence

    sequence rd_ch2_s;
        s_q.loaded && req.rd && req.addr == rcc_pkg::CH2_OFS;
    endsequence

    sequence rd_none_s;
        req.rd && req.addr != rcc_pkg::CH1_OFS && req.addr != rcc_pkg::CH2_OFS;
    endsequence

    sequence wr_none_s;
        s_q.loaded && req.wr && req.addr != rcc_pkg::CH1_OFS
            && req.addr != rcc_pkg::CH2_OFS;
    endsequence

    // Style is a plain field, so it shows one edge after the write
    style_follows_a: assert property (wr_ch1_s |=> ch1_style == $past(req.wdata[7:6])) // see [RULE1]
        else $error("style not taken from write");
    limit_map_a: assert property (wr_ch1_s ##2 1'b1 |-> ($past(req.wdata[5:4], 2) == 2'b11)
        == (ch1_peak_limit_ma == rcc_pkg::ILIM_11_MA)) // see [RULE2]
        else $error("peak limit code 3 mismatch");
    disch_off_a: assert property (ch1_discharge_on |-> !ch1_on) // see [RULE3]
        else $error("discharge while channel on");
    // Watches the outputs, not the next-state copy, so a broken gate shows
    disch_en_a: assert property (s_q.ch1.discharge_enable_ch1 ##1 !ch1_on |-> ch1_discharge_on) // see [RULE3]
        else $error("discharge missing while off");
    slot_follow_a: assert property (s_q.loaded && !s_q.ch1.enable_control_ch1[2]
        |=> ch1_on == $past(slot_on[s_q.ch1.enable_control_ch1[1:0]])) // see [RULE4]
        else $error("channel ignores its slot");
    forced_a: assert property (s_q.loaded && s_q.ch1.enable_control_ch1[2]
        |=> ch1_on == $past(s_q.ch1.enable_control_ch1[1])) // see [RULE5]
        else $error("forced enable ignored");
    setpoint_a: assert property (wr_ch2_s ##0 req.wdata < rcc_pkg::VSAT_CODE
        |-> ##2 ch2_setpoint_mv == 16'(rcc_pkg::VMIN_MV
        + 16'($past(req.wdata, 2)) * rcc_pkg::VSTEP_MV)) // see [RULE7]
        else $error("setpoint not linear");
    saturate_a: assert property (ch2_setpoint_mv <= rcc_pkg::VMAX_MV) // see [RULE8]
        else $error("setpoint above maximum");
    load_a: assert property ($rose(s_q.loaded) |-> s_q.ch1 == $past(factory_ch1)
        && s_q.ch2 == $past(factory_ch2)) // see [RULE9]
        else $error("factory settings not loaded");

    // Remaining limit codes, each two edges after the write
    limit_1000_a: assert property (wr_ch1_s ##2 1'b1 |-> ($past(req.wdata[5:4], 2) == 2'b00)
        == (ch1_peak_limit_ma == rcc_pkg::ILIM_00_MA)) // see [RULE2]
        else $error("peak limit code 0 mismatch");
    limit_750_a: assert property (wr_ch1_s ##2 1'b1 |-> ($past(req.wdata[5:4], 2) == 2'b01)
        == (ch1_peak_limit_ma == rcc_pkg::ILIM_01_MA)) // see [RULE2]
        else $error("peak limit code 1 mismatch");
    limit_500_a: assert property (wr_ch1_s ##2 1'b1 |-> ($past(req.wdata[5:4], 2) == 2'b10)
        == (ch1_peak_limit_ma == rcc_pkg::ILIM_10_MA)) // see [RULE2]
        else $error("peak limit code 2 mismatch");

    // High codes clamp rather than wrap past the top of the range
    sat_code_a: assert property (wr_ch2_s ##0 req.wdata >= rcc_pkg::VSAT_CODE
        |-> ##2 ch2_setpoint_mv == rcc_pkg::VMAX_MV) // see [RULE8]
        else $error("high code not clamped");

    // Read port: one pulse per request, data from the old register value
    rd_pulse_a: assert property (req.rd |=> rd_valid) // see [RULE9]
        else $error("read not answered");
    rd_idle_a: assert property (!req.rd |=> !rd_valid) // see [RULE9]
        else $error("read valid without request");
    rd_ch1_a: assert property (rd_ch1_s |=> rd_data == $past(s_q.ch1)) // see [RULE9]
        else $error("channel 1 read data wrong");
    rd_ch2_a: assert property (rd_ch2_s |=> rd_data == $past(s_q.ch2)) // see [RULE9]
        else $error("channel 2 read data wrong");
    rd_unmapped_a: assert property (rd_none_s |=> rd_data == 8'h00) // see [RULE9]
        else $error("unmapped read not zero");

    // Writes elsewhere in the map must leave both registers alone
    wr_ignored_a: assert property (wr_none_s |=> $stable(s_q.ch1) && $stable(s_q.ch2)) // see [RULE9]
        else $error("unmapped write changed a register");
    style_hold_a: assert property (s_q.loaded && !(req.wr && req.addr == rcc_pkg::CH1_OFS)
        |=> $stable(ch1_style)) // see [RULE9]
        else $error("style changed without a write");
endmodule // rcc_regs
`default_nettype wire

/* File: core/rcc_pkg.sv */
// Shared constants and types for the regulator channel configuration registers.
// Assumes one 100 MHz clock and an upstream serial port that issues word accesses.
`default_nettype none
package rcc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] CH1_OFS = 8'h2c;
    localparam logic [7:0] CH2_OFS = 8'h2d;
    localparam int STYLE_LSB = 6;
    localparam int ILIM_LSB = 4;
    localparam int DISCH_BIT = 3;
    localparam int EN_LSB = 0;
    localparam int EN_FORCE_BIT = 2;
    localparam int EN_ON_BIT = 1;
    localparam logic [9:0] ILIM_00_MA = 10'd1000;
    localparam logic [9:0] ILIM_01_MA = 10'd750;
    localparam logic [9:0] ILIM_10_MA = 10'd500;
    localparam logic [9:0] ILIM_11_MA = 10'd333;
    localparam logic [15:0] VMIN_MV = 16'd500;
    localparam logic [15:0] VSTEP_MV = 16'd25;
    localparam logic [15:0] VMAX_MV = 16'd5500;
    localparam logic [7:0] VSAT_CODE = 8'hc8;
    localparam int SLOTS = 4;

    typedef enum logic [1:0] {
        RCC_AUTO,
        RCC_BUCK,
        RCC_BOOST,
        RCC_BUCK_BOOST
    } rcc_style_e;

    typedef struct packed {
        rcc_style_e conversion_style;
        logic [1:0] peak_current_limit_ch1;
        logic discharge_enable_ch1;
        logic [2:0] enable_control_ch1;
    } rcc_ch1_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } rcc_req_s;
endpackage
`default_nettype wire

/* File: core/rcc_vdecode.sv */
// Target voltage code to millivolt setpoint, combinational.
// Assumes the caller registers the result.
`default_nettype none
module rcc_vdecode (
    input wire logic [7:0] code,
    output logic [15:0] setpoint_mv
);
    always_comb begin
        if (code >= rcc_pkg::VSAT_CODE) begin
            setpoint_mv = rcc_pkg::VMAX_MV; // see [RULE8]
        end else begin
            setpoint_mv = 16'(rcc_pkg::VMIN_MV + 16'(code) * rcc_pkg::VSTEP_MV); // see [RULE7]
        end
    end
endmodule // rcc_vdecode
`default_nettype wire

/* File: verif/rcc_regs_tb_top.sv */
// Bench for the channel configuration registers: a row table, then hand-written cases.
// Assumes writes show on the outputs two edges after they are taken (style one edge), and reads one edge after.
`default_nettype none
module rcc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] ch1;
        logic [7:0] ch2;
        logic [3:0] slot;
        logic on;
        logic dis;
        logic [9:0] ma;
        logic [15:0] mv;
    } rcc_row_s;
    localparam rcc_row_s ROWS [8] = '{
        '{8'h08, 8'h00, 4'h1, 1'b1, 1'b0, 10'h3e8, 16'h01f4},
        '{8'h59, 8'h01, 4'h1, 1'b0, 1'b1, 10'h2ee, 16'h020d},
        '{8'ha2, 8'hc7, 4'h4, 1'b1, 1'b0, 10'h1f4, 16'h1563},
        '{8'hfb, 8'hc8, 4'h7, 1'b0, 1'b1, 10'h14d, 16'h157c},
        '{8'h0c, 8'hff, 4'hf, 1'b0, 1'b1, 10'h3e8, 16'h157c},
        '{8'h0d, 8'h10, 4'hf, 1'b0, 1'b1, 10'h3e8, 16'h0384},
        '{8'h36, 8'h50, 4'h0, 1'b1, 1'b0, 10'h14d, 16'h09c4},
        '{8'h67, 8'h80, 4'h0, 1'b1, 1'b0, 10'h1f4, 16'h0e74}};
    logic clk = 1'b0;
    logic resetn;
    rcc_pkg::rcc_req_s req;
    logic [7:0] rd_data, factory_ch1, factory_ch2;
    logic rd_valid, ch1_on, ch1_discharge_on;
    logic [3:0] slot_on;
    rcc_pkg::rcc_style_e ch1_style;
    logic [9:0] ch1_peak_limit_ma;
    logic [15:0] ch2_setpoint_mv;
    int bad_count = 0;
    int n_compared = 0;
    rcc_regs u_rcc_regs (.clk(clk), .resetn(resetn), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .factory_ch1(factory_ch1), .factory_ch2(factory_ch2),
        .slot_on(slot_on), .ch1_on(ch1_on), .ch1_discharge_on(ch1_discharge_on),
        .ch1_style(ch1_style), .ch1_peak_limit_ma(ch1_peak_limit_ma),
        .ch2_setpoint_mv(ch2_setpoint_mv));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access per call; the idle cycle after it keeps drivers apart
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: w, rd: r, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, a, 8'h00);
        chk(rd_valid, 1'b1);
        chk(rd_data, exp);
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        chk(ch2_setpoint_mv, 16'h0000);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        req = '0;
        factory_ch1 = 8'he5;
        factory_ch2 = 8'hc8;
        slot_on = 4'h0;
        do_reset();
        chk(ch1_style, 2'h3);
        chk(ch1_peak_limit_ma, 10'h1f4);
        chk(ch2_setpoint_mv, 16'h157c);
        rd(rcc_pkg::CH1_OFS, 8'he5);
        // Bias power mode lives outside this block; software orders it
        foreach (ROWS[i]) begin
            slot_on = ROWS[i].slot;
            acc(1'b1, 1'b0, rcc_pkg::CH1_OFS, ROWS[i].ch1);
            acc(1'b1, 1'b0, rcc_pkg::CH2_OFS, ROWS[i].ch2);
            @(negedge clk);
            chk(ch1_on, ROWS[i].on);
            chk(ch1_discharge_on, ROWS[i].dis);
            chk(ch1_style, ROWS[i].ch1[7:6]);
            chk(ch1_peak_limit_ma, ROWS[i].ma);
            chk(ch2_setpoint_mv, ROWS[i].mv);
            rd(rcc_pkg::CH1_OFS, ROWS[i].ch1);
            rd(rcc_pkg::CH2_OFS, ROWS[i].ch2);
        end
        // Unmapped place: write ignored, read gives zero
        acc(1'b1, 1'b0, 8'h2e, 8'hff);
        rd(8'h2e, 8'h00);
        rd(rcc_pkg::CH2_OFS, 8'h80);
        // Read and write together return the old value
        acc(1'b1, 1'b1, rcc_pkg::CH1_OFS, 8'h09);
        chk(rd_valid, 1'b1);
        chk(rd_data, 8'h67);
        slot_on = 4'hd;
        repeat (2) @(negedge clk);
        chk(ch1_on, 1'b0);
        chk(ch1_discharge_on, 1'b1);
        slot_on = 4'h2;
        @(negedge clk);
        chk(ch1_on, 1'b1);
        chk(ch1_discharge_on, 1'b0);
        // Second reset with other factory values
        factory_ch1 = 8'h0e;
        factory_ch2 = 8'h50;
        do_reset();
        chk(ch1_on, 1'b1);
        chk(ch2_setpoint_mv, 16'h09c4);
        rd(rcc_pkg::CH2_OFS, 8'h50);
        stop_test();
    end
    initial begin
        #50us;
        bad_count++;
        stop_test();
    end
endmodule // rcc_regs_tb_top
`default_nettype wire
